// ### logic/fcp_flash_config.sv
// flash configuration and protection logic
`timescale 1ns/10ps
// Functional notes
// R1: mcu cannot erase/write protected pages
// R2: 32 pages; count 0xff leaves all unprotected
// R3: pages at or above count are protected
// R4: boot address 0 or first protected page
// R5: boot flag is parity of nv top
// R6: lock byte set blocks external main access
// R7: only full wipe lifts lock, erases config
// R8: programmer sends lock command last
// R9: programmer saves tuning area before wipe
// R10: debug byte set enables debug and jtag
// R11: boot copies config page into registers
// R12: debug bit resets 0, mcu set only
// R13: write latch gates spi, auto-clears after
// R14: ready flag resets 1, read only
// R15: redirect routes spi to config page
// R16: lock bit resets 1, mcu read only
// R17: page count read only, reserves nv top
// R18: erase command erases pages below 36
// R19: status write ignores lock and debug
// R20: count loaded from config byte 0x20
// R21: status write command carries one byte
// R22: counts 32..0xfe mean all unprotected; code keeps count bits 6:0 only, so 0x80..0x9f act as 0..0x1f
module fcp_flash_config (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire fcp_pkg::fcp_sfr_req_t sfrReq,
    input wire fcp_pkg::fcp_spi_cmd_t spiCmd,
    input wire logic mcuWriteReq,
    input wire logic [7:0] mcuWritePage,
    input wire logic [7:0] cfgRdata,
    input wire logic [7:0] nvRdata,
    output logic [8:0] cfgAddr,
    output logic [3:0] nvIndex,
    output logic [7:0] sfrRdata,
    output logic [7:0] spiStatus,
    output logic spiRefused,
    output fcp_pkg::fcp_flash_op_t flashOp,
    output logic mcuWriteOk,
    output logic [15:0] bootAddr,
    output logic debugOn
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic debugBit, bootBit, wen, readyN, redirect, lockN, rsv0;
    logic [6:0] pageCount;
    logic [7:0] eraseCmd;
    fcp_pkg::fcp_boot_t bootState;
    logic [8:0] next_cfgAddr;
    logic [3:0] nvCnt;
    logic parity;
    logic spiWen, spiWdis, spiStat, spiProg, spiPage, spiAll, spiLock;
    logic spiRead, spiMain, spiBad;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // status byte as both ports read it
    function automatic logic [7:0] statusByte(input logic dbg, boot, wl,
                                              input logic ready_n_flag, redir, lk,
                                              input logic r0);
        return {dbg, boot, wl, ready_n_flag, redir, lk, fcp_pkg::RST_RSV1, r0};
    endfunction

    // page is protected against mcu erase/write
    function automatic logic isProtected(input logic [7:0] page,
                                         input logic [6:0] count);
        logic [7:0] c;
        c = {1'b0, count};
        if (c >= fcp_pkg::CODE_PAGES)
            return 1'b0; // R2 R22
        return page < fcp_pkg::CODE_PAGES && page >= c; // R3
    endfunction

    // ------------------------------------------------------------
    // spi command decode
    // ------------------------------------------------------------
    always_comb begin
        spiWen = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_WREN;
        spiWdis = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_WRDIS;
        spiStat = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_STATUS_WRITE;
        spiRead = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_READ;
        spiProg = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_PROGRAM;
        spiPage = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_ERASE_PAGE;
        spiAll = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_ERASE_ALL;
        spiLock = spiCmd.valid && spiCmd.opcode == fcp_pkg::OP_LOCK;
        // main block traffic unless redirected to the config page
        spiMain = !redirect; // R15
        // while locked: no main access, config page read only
        spiBad = lockN && (((spiRead || spiProg || spiPage) && spiMain)
                 || ((spiProg || spiPage) && !spiMain)); // R6 R16
        // array writes also need the write latch
        if ((spiProg || spiPage) && !wen)
            spiBad = 1'b1; // R13
        if (readyN && spiCmd.valid)
            spiBad = 1'b1;
    end

    // ------------------------------------------------------------
    // boot sequence: config page readout, then nv parity
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            bootState <= fcp_pkg::BOOT_IDLE;
            cfgAddr <= '0;
            nvCnt <= '0;
            parity <= 1'b0;
        end else if (clkEn) begin
            case (bootState)
                fcp_pkg::BOOT_IDLE: begin
                    bootState <= fcp_pkg::BOOT_CFG;
                    cfgAddr <= fcp_pkg::CFG_PAGE_COUNT;
                end
                fcp_pkg::BOOT_CFG: begin
                    cfgAddr <= next_cfgAddr;
                    if (cfgAddr == fcp_pkg::CFG_DEBUG)
                        bootState <= fcp_pkg::BOOT_NV;
                end
                fcp_pkg::BOOT_NV: begin
                    parity <= parity ^ (^nvRdata); // R5
                    nvCnt <= nvCnt + 4'h1;
                    if (nvCnt == 4'(fcp_pkg::NV_TOP_BYTES - 1))
                        bootState <= fcp_pkg::BOOT_DONE;
                end
                fcp_pkg::BOOT_DONE: begin
                    bootState <= fcp_pkg::BOOT_DONE;
                end
                default: begin
                    bootState <= fcp_pkg::BOOT_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        next_cfgAddr = cfgAddr + 9'h001;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            nvIndex <= '0;
        end else if (clkEn) begin
            // address runs one ahead so nvRdata matches nvCnt
            if (bootState == fcp_pkg::BOOT_NV)
                nvIndex <= nvCnt + 4'h1; // R5
        end
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            debugBit <= 1'b0; // R12
            bootBit <= 1'b0;
            readyN <= fcp_pkg::RST_READY_N; // R14
            lockN <= fcp_pkg::RST_LOCK; // R16
            pageCount <= fcp_pkg::RST_PAGE_COUNT;
        end else if (clkEn) begin
            if (bootState == fcp_pkg::BOOT_CFG) begin
                case (cfgAddr)
                    fcp_pkg::CFG_PAGE_COUNT:
                        pageCount <= cfgRdata[6:0]; // R11 R20 R17
                    fcp_pkg::CFG_LOCK:
                        lockN <= cfgRdata != fcp_pkg::BYTE_UNSET; // R11
                    fcp_pkg::CFG_DEBUG: begin
                        debugBit <= cfgRdata != fcp_pkg::BYTE_UNSET; // R10
                        readyN <= 1'b0; // R14
                    end
                    default: begin
                        readyN <= readyN;
                    end
                endcase
            end
            if (bootState == fcp_pkg::BOOT_NV
                    && nvCnt == 4'(fcp_pkg::NV_TOP_BYTES - 1))
                bootBit <= parity ^ (^nvRdata); // R5
            // mcu may only set the debug bit, and only when unlocked
            if (sfrReq.wr && sfrReq.addr == fcp_pkg::ADDR_STATUS && !lockN
                    && sfrReq.wdata[fcp_pkg::BIT_DEBUG])
                debugBit <= 1'b1; // R12
            // lock byte written once by its dedicated command
            if (spiLock && !readyN)
                lockN <= 1'b1; // R19
            // wipe clears the whole config page, so all bytes read 0xff
            // a wipe without the latch changes nothing
            if (spiAll && !readyN && wen) begin
                lockN <= 1'b0; // R7
                debugBit <= 1'b0;
                pageCount <= fcp_pkg::RST_PAGE_COUNT;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wen <= 1'b0; // R13
            redirect <= 1'b0;
            rsv0 <= 1'b0;
        end else if (clkEn) begin
            if (sfrReq.wr && sfrReq.addr == fcp_pkg::ADDR_STATUS) begin
                wen <= sfrReq.wdata[fcp_pkg::BIT_WEN];
                redirect <= sfrReq.wdata[fcp_pkg::BIT_REDIRECT];
                rsv0 <= sfrReq.wdata[fcp_pkg::BIT_RSV0];
            end
            // one data byte; lock and debug bits not touched
            if (spiStat && !readyN) begin
                wen <= spiCmd.data[fcp_pkg::BIT_WEN]; // R21 R19
                redirect <= spiCmd.data[fcp_pkg::BIT_REDIRECT]; // R15
            end
            if (spiWen && !readyN)
                wen <= 1'b1;
            if (spiWdis && !readyN)
                wen <= 1'b0;
            // spi array writes consume the latch; mcu ones do not
            if ((spiProg || spiPage || spiAll) && !spiBad)
                wen <= 1'b0; // R13
        end
    end

    // ------------------------------------------------------------
    // mcu erase command register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            eraseCmd <= fcp_pkg::RST_ERASE_CMD;
        end else if (clkEn) begin
            if (sfrReq.wr && sfrReq.addr == fcp_pkg::ADDR_ERASE_CMD)
                eraseCmd <= sfrReq.wdata;
        end
    end

    // ------------------------------------------------------------
    // flash operations and outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flashOp <= '0;
            spiRefused <= 1'b0;
            mcuWriteOk <= 1'b0;
        end else if (clkEn) begin
            flashOp <= '0;
            spiRefused <= spiBad;
            mcuWriteOk <= mcuWriteReq && wen
                && !isProtected(mcuWritePage, pageCount); // R1
            if (sfrReq.wr && sfrReq.addr == fcp_pkg::ADDR_ERASE_CMD
                    && sfrReq.wdata < fcp_pkg::ERASE_LIMIT // R18
                    && wen
                    && !isProtected(sfrReq.wdata, pageCount)) begin // R1
                flashOp.valid <= 1'b1;
                flashOp.erase <= 1'b1;
                flashOp.page <= sfrReq.wdata;
            end
            // spi may erase/write protected pages unless locked
            if ((spiProg || spiPage) && !spiBad) begin
                flashOp.valid <= 1'b1;
                flashOp.erase <= spiPage;
                flashOp.cfgPage <= !spiMain; // R15
                flashOp.page <= spiCmd.page;
            end
            if (spiAll && !readyN && wen) begin
                flashOp.valid <= 1'b1;
                flashOp.erase <= 1'b1;
                flashOp.all <= 1'b1; // R7 R15
                flashOp.cfgPage <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sfrRdata <= '0;
            spiStatus <= {3'b000, fcp_pkg::RST_READY_N, 1'b0,
                          fcp_pkg::RST_LOCK, fcp_pkg::RST_RSV1, 1'b0}; // R14
            bootAddr <= '0;
            debugOn <= 1'b0;
        end else if (clkEn) begin
            // status readable identically from both ports
            spiStatus <= statusByte(debugBit, bootBit, wen, readyN, redirect,
                                    lockN, rsv0);
            case (sfrReq.addr)
                fcp_pkg::ADDR_STATUS:
                    sfrRdata <= statusByte(debugBit, bootBit, wen, readyN,
                                           redirect, lockN, rsv0);
                fcp_pkg::ADDR_PROTECT:
                    sfrRdata <= {1'b1, pageCount}; // R17
                fcp_pkg::ADDR_ERASE_CMD:
                    sfrRdata <= eraseCmd;
                default:
                    sfrRdata <= '0;
            endcase
            debugOn <= debugBit; // R10
            if (bootBit && {1'b0, pageCount} < fcp_pkg::CODE_PAGES)
                bootAddr <= 16'({pageCount, 9'h000}); // R4
            else
                bootAddr <= 16'h0000; // R4
        end
    end
endmodule

// ### inc/fcp_pkg.sv
// package: constants and carriers for the flash configuration/protection block
package fcp_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'hf8;
    localparam logic [7:0] ADDR_PROTECT = 8'hf9;
    localparam logic [7:0] ADDR_ERASE_CMD = 8'hfa;
    // status and protect bit positions
    localparam int BIT_DEBUG = 7;
    localparam int BIT_BOOT = 6;
    localparam int BIT_WEN = 5;
    localparam int BIT_READY_N = 4;
    localparam int BIT_REDIRECT = 3;
    localparam int BIT_LOCK = 2;
    localparam int BIT_RSV1 = 1;
    localparam int BIT_RSV0 = 0;
    localparam int BIT_PROT_RSV = 7;
    // reset values
    localparam logic [7:0] RST_ERASE_CMD = 8'h00;
    localparam logic [6:0] RST_PAGE_COUNT = 7'h7f;
    localparam logic RST_LOCK = 1'b1;
    localparam logic RST_READY_N = 1'b1;
    localparam logic RST_RSV1 = 1'b1;
    // ------------------------------------------------------------
    // geometry and config page layout
    // ------------------------------------------------------------
    localparam logic [7:0] CODE_PAGES = 8'h20;
    localparam logic [7:0] ERASE_LIMIT = 8'h24;
    localparam logic [7:0] BYTE_UNSET = 8'hff;
    localparam logic [8:0] CFG_PAGE_COUNT = 9'h020;
    localparam logic [8:0] CFG_LOCK = 9'h023;
    localparam logic [8:0] CFG_DEBUG = 9'h024;
    localparam int PAGE_SHIFT = 9;
    localparam int NV_TOP_BYTES = 16;
    // ------------------------------------------------------------
    // spi opcodes seen by this block
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDIS = 8'h04;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_ERASE_PAGE = 8'h52;
    localparam logic [7:0] OP_ERASE_ALL = 8'h62;
    localparam logic [7:0] OP_LOCK = 8'h85;

    // one decoded spi command from the programmer front end
    typedef struct packed {
        logic valid;
        logic [7:0] opcode;
        logic [7:0] data;
        logic [7:0] page;
    } fcp_spi_cmd_t;

    // one mcu special-register access
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fcp_sfr_req_t;

    // flash operation requested towards the array
    typedef struct packed {
        logic valid;
        logic erase;
        logic all;
        logic cfgPage;
        logic [7:0] page;
    } fcp_flash_op_t;

    typedef enum logic [3:0] {
        BOOT_IDLE = 4'b0001,
        BOOT_CFG = 4'b0010,
        BOOT_NV = 4'b0100,
        BOOT_DONE = 4'b1000
    } fcp_boot_t;
endpackage

// ### verification/fcp_mem_model.sv
// memory model: config page bytes and nv top bytes behind the block
`timescale 1ns/10ps
module fcp_mem_model (
    input wire logic [8:0] cfgAddr,
    input wire logic [3:0] nvIndex,
    input wire logic [7:0] pageCount,
    input wire logic [7:0] lockByte,
    input wire logic [7:0] debugByte,
    input wire logic nvOdd,
    output logic [7:0] cfgRdata,
    output logic [7:0] nvRdata
);
    // ------------------------------------------------------------
    // config page, combinational read
    // ------------------------------------------------------------
    // tuning area below 0x20 reads a fixed pattern, 0x5a
    always_comb begin
        case (cfgAddr)
            fcp_pkg::CFG_PAGE_COUNT: cfgRdata = pageCount;
            fcp_pkg::CFG_LOCK: cfgRdata = lockByte;
            fcp_pkg::CFG_DEBUG: cfgRdata = debugByte;
            default: cfgRdata = (cfgAddr < 9'h020) ? 8'h5a : 8'hff;
        endcase
    end
    // one set bit in the last byte, so skipping that last top byte shows up
    assign nvRdata = (nvOdd && nvIndex == 4'hf) ? 8'h01 : 8'h00;
endmodule

// ### verification/fcp_flash_config_chk.sv
// checker: port-level assertions for the flash configuration block
`timescale 1ns/10ps
module fcp_flash_config_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clkEn,
    input wire fcp_pkg::fcp_sfr_req_t sfrReq,
    input wire fcp_pkg::fcp_spi_cmd_t spiCmd,
    input wire logic [7:0] spiStatus,
    input wire logic spiRefused,
    input wire fcp_pkg::fcp_flash_op_t flashOp,
    input wire logic [15:0] bootAddr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------
    // helpers and assertions
    // ------------------------------------------------------------
    // spi traffic is kept out of eraseWr so flashOp has one cause
    logic go, eraseWr, wipe;
    assign go = clkEn && spiCmd.valid;
    assign eraseWr = clkEn && sfrReq.wr && sfrReq.addr == 8'hfa && !go;
    assign wipe = go && spiCmd.opcode == 8'h62;
    erase_limit_a: assert property (
        eraseWr && sfrReq.wdata > 8'h23 |=> !flashOp.valid)
        else $error("erase above page 35 acted");
    erase_page_a: assert property (
        eraseWr |=> !flashOp.valid
        || (flashOp.erase && flashOp.page == $past(sfrReq.wdata)))
        else $error("mcu erase on wrong page");
    boot_refuse_a: assert property (
        go && spiStatus[4] |=> spiRefused)
        else $error("spi taken before ready");
    lock_refuse_a: assert property (
        go && spiCmd.opcode == 8'h03 && spiStatus[2] && !spiStatus[3]
        |=> spiRefused) else $error("locked read not refused");
    wen_gate_a: assert property (
        go && spiCmd.opcode == 8'h02 && !spiStatus[5]
        |=> spiRefused && !flashOp.valid) else $error("program w/o latch");
    wipe_unlock_a: assert property (
        wipe && spiStatus[5] && !spiStatus[4]
        |-> ##[1:2] !spiStatus[2] && !spiStatus[7])
        else $error("wipe left lock or debug set");
    debug_keep_a: assert property (
        $fell(spiStatus[7]) |-> $past(wipe) || $past(wipe, 2))
        else $error("debug bit cleared without wipe");
    boot_addr_a: assert property (
        bootAddr != 16'h0000 |-> bootAddr[8:0] == 9'h000
        && bootAddr[15:14] == 2'b00) else $error("boot address off page");
    cover property (wipe);
    cover property (eraseWr ##1 flashOp.valid);
    cover property (bootAddr != 16'h0000);
endmodule
bind fcp_flash_config fcp_flash_config_chk u_chk (.ref_clk(ref_clk),
    .arst_n(arst_n), .clkEn(clkEn), .sfrReq(sfrReq), .spiCmd(spiCmd),
    .spiStatus(spiStatus), .spiRefused(spiRefused), .flashOp(flashOp),
    .bootAddr(bootAddr));

// ### verification/tb.sv
// testbench: directed scenarios for the flash configuration block
`timescale 1ns/10ps
module tb;
    logic ref_clk, arst_n, clkEn, mcuWriteReq, spiRefused, mcuWriteOk;
    logic debugOn, nvOdd;
    logic [7:0] mcuWritePage, cfgRdata, nvRdata, sfrRdata, spiStatus;
    logic [7:0] pageCount, lockByte, debugByte;
    logic [8:0] cfgAddr;
    logic [3:0] nvIndex;
    logic [15:0] bootAddr;
    fcp_pkg::fcp_sfr_req_t sfrReq;
    fcp_pkg::fcp_spi_cmd_t spiCmd;
    fcp_pkg::fcp_flash_op_t flashOp;
    int error_cnt = 0;
    int checks = 0;
    fcp_flash_config u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
        .clkEn(clkEn), .sfrReq(sfrReq), .spiCmd(spiCmd),
        .mcuWriteReq(mcuWriteReq), .mcuWritePage(mcuWritePage),
        .cfgRdata(cfgRdata), .nvRdata(nvRdata), .cfgAddr(cfgAddr),
        .nvIndex(nvIndex), .sfrRdata(sfrRdata), .spiStatus(spiStatus),
        .spiRefused(spiRefused), .flashOp(flashOp),
        .mcuWriteOk(mcuWriteOk), .bootAddr(bootAddr), .debugOn(debugOn));
    fcp_mem_model u_mem (.cfgAddr(cfgAddr), .nvIndex(nvIndex),
        .pageCount(pageCount), .lockByte(lockByte),
        .debugByte(debugByte), .nvOdd(nvOdd), .cfgRdata(cfgRdata),
        .nvRdata(nvRdata));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [15:0] opx(input logic e, c, logic [7:0] p);
        return {4'h0, 1'b1, e, 1'b0, c, p};
    endfunction
    // ------------------------------------------------------------
    // port drivers: request held until the taking edge
    // ------------------------------------------------------------
    task automatic spi(input logic [7:0] op, d, output logic r,
        output fcp_pkg::fcp_flash_op_t o);
        @(posedge ref_clk);
        spiCmd <= '{1'b1, op, d, d};
        @(posedge ref_clk);
        spiCmd.valid <= 1'b0;
        #1;
        r = spiRefused;
        o = flashOp;
    endtask
    task automatic sw(input logic [7:0] a, d,
        output fcp_pkg::fcp_flash_op_t o);
        @(posedge ref_clk);
        sfrReq <= '{1'b1, a, d};
        @(posedge ref_clk);
        sfrReq.wr <= 1'b0;
        #1;
        o = flashOp;
    endtask
    task automatic mw(input logic [7:0] p, output logic k);
        @(posedge ref_clk);
        mcuWriteReq <= 1'b1;
        mcuWritePage <= p;
        @(posedge ref_clk);
        mcuWriteReq <= 1'b0;
        #1;
        k = mcuWriteOk;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        sfrReq <= '{1'b0, a, 8'h00};
        repeat (2) @(posedge ref_clk);
        #1;
        v = sfrRdata;
    endtask
    // spi before ready is refused; nv walk takes a fixed 16 cycles
    task automatic boot(input logic [7:0] c, l, d, input logic n);
        logic r;
        fcp_pkg::fcp_flash_op_t o;
        @(posedge ref_clk);
        arst_n <= 1'b0;
        {pageCount, lockByte, debugByte, nvOdd} <= {c, l, d, n};
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        spi(8'h06, 8'h00, r, o);
        cmp(r, 1'b1);
        for (int i = 0; i < 60 && spiStatus[4] !== 1'b0; i++) begin
            @(posedge ref_clk);
            #1;
        end
        cmp(spiStatus[4], 1'b0);
        repeat (20) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_open;
        logic [7:0] v;
        logic r;
        fcp_pkg::fcp_flash_op_t o;
        boot(8'hff, 8'hff, 8'hff, 1'b0);
        rd(8'hf8, v);
        cmp(v, 8'h02);
        rd(8'hf9, v);
        cmp(v, 8'hff);
        rd(8'hfa, v);
        cmp(v, 8'h00);
        sw(8'hfa, 8'h1f, o);
        cmp(o.valid, 1'b0);
        sw(8'hf8, 8'h20, o);
        sw(8'hfa, 8'h1f, o);
        cmp(o, opx(1'b1, 1'b0, 8'h1f));
        spi(8'h02, 8'h05, r, o);
        cmp(o, opx(1'b0, 1'b0, 8'h05));
        spi(8'h02, 8'h05, r, o);
        cmp(r, 1'b1);
        sw(8'hf8, 8'h80, o);
        rd(8'hf8, v);
        cmp(v[7], 1'b1);
        cmp(debugOn, 1'b1);
        spi(8'h01, 8'h28, r, o);
        spi(8'h02, 8'h01, r, o);
        cmp(o, opx(1'b0, 1'b1, 8'h01));
        spi(8'h06, 8'h00, r, o);
        spi(fcp_pkg::OP_LOCK, 8'h00, r, o);
        spi(8'h01, 8'h00, r, o);
        spi(8'h03, 8'h00, r, o);
        cmp(r, 1'b1);
        $display("done open");
    endtask
    task automatic t_split;
        logic [7:0] v;
        logic r;
        fcp_pkg::fcp_flash_op_t o;
        boot(8'h0c, 8'hff, 8'hff, 1'b1);
        cmp(bootAddr, 16'h1800);
        rd(8'hf8, v);
        cmp(v, 8'h42);
        sw(8'hf9, 8'h00, o);
        rd(8'hf9, v);
        cmp(v, 8'h8c);
        sw(8'hf8, 8'h20, o);
        sw(8'hfa, 8'h0b, o);
        cmp(o, opx(1'b1, 1'b0, 8'h0b));
        sw(8'hfa, 8'h0c, o);
        cmp(o.valid, 1'b0);
        sw(8'hfa, 8'h21, o);
        cmp(o, opx(1'b1, 1'b0, 8'h21));
        sw(8'hfa, 8'h24, o);
        cmp(o.valid, 1'b0);
        mw(8'h0b, r);
        cmp(r, 1'b1);
        mw(8'h0c, r);
        cmp(r, 1'b0);
        spi(8'h52, 8'h0c, r, o);
        cmp(o, opx(1'b1, 1'b0, 8'h0c));
        rd(8'hf8, v);
        cmp(v[5], 1'b0);
        $display("done split");
    endtask
    task automatic t_lock;
        logic [7:0] v;
        logic r;
        fcp_pkg::fcp_flash_op_t o;
        boot(8'h40, 8'h00, 8'h00, 1'b1);
        cmp(bootAddr, 16'h0000);
        sw(8'hf8, 8'h00, o);
        rd(8'hf8, v);
        cmp(v, 8'hc6);
        spi(8'h03, 8'h00, r, o);
        cmp(r, 1'b1);
        spi(8'h01, 8'h28, r, o);
        spi(8'h03, 8'h00, r, o);
        cmp(r, 1'b0);
        spi(8'h02, 8'h00, r, o);
        cmp(r, 1'b1);
        spi(8'h06, 8'h00, r, o);
        spi(8'h62, 8'h00, r, o);
        cmp({o.valid, o.all}, 2'b11);
        rd(8'hf8, v);
        cmp({v[7], v[2]}, 2'b00);
        spi(8'h01, 8'h00, r, o);
        spi(8'h03, 8'h00, r, o);
        cmp(r, 1'b0);
        $display("done lock");
    endtask
    initial begin
        {arst_n, clkEn, mcuWriteReq, mcuWritePage} = {3'b010, 8'h00};
        sfrReq = '0;
        spiCmd = '0;
        {pageCount, lockByte, debugByte, nvOdd} = 25'h1fffffe;
        t_open;
        t_split;
        t_lock;
        end_of_test;
    end
    // the whole run is a few hundred cycles
    initial begin
        repeat (5000) @(posedge ref_clk);
        error_cnt++;
        end_of_test;
    end
endmodule
